// file: bench/clock_synth_smbus_control_bench.sv
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ns
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module clock_synth_smbus_control_bench;
  int          num_errors = 0, num_checks = 0, cycles = 0;
  logic        sys_clk = 1'b0, rst_n = 1'b0, pci_boundary = 1'b0;
  logic        power_down_n = 1'b1, pci_stop_n = 1'b1, strap_valid_n = 1'b1;
  logic        mode_select_mid = 1'b0, mode_select_tri = 1'b1;
  logic        cpu_freq_select = 1'b1, current_multiplier_select = 1'b0;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [3:0]  avs_address = 4'h0, out_mode;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [7:0]  ctrl0_q, b_ctrl0;
  logic        spread_enable, video_hub_48, pci_run, cpu_133, outputs_hiz;
  logic        outputs_held_low, osc_vco_on, cpu_cur_mult_6, transfer_valid;
  logic        b_pci_run, b_valid;
  cssc_smbus_if link ();
  cssc_smbus_if bad ();
  // ==========================================================
  // Clock, instances and watchdog
  always #4 sys_clk = ~sys_clk;
  cssc_host i_cssc_host (.sys_clk, .rst_n, .bus(link.host), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  cssc_device i_cssc_device (.sys_clk, .rst_n, .bus(link.dev), .power_down_n,
    .pci_stop_n, .strap_valid_n, .mode_select_mid, .mode_select_tri,
    .cpu_freq_select, .current_multiplier_select, .pci_boundary, .ctrl0_q,
    .spread_enable, .video_hub_48, .pci_run, .cpu_133, .out_mode,
    .outputs_hiz, .outputs_held_low, .osc_vco_on, .cpu_cur_mult_6,
    .transfer_valid);
  // Second device faces the rule-breaking bit driver below
  cssc_device i_cssc_device_b (.sys_clk, .rst_n, .bus(bad.dev), .power_down_n,
    .pci_stop_n, .strap_valid_n, .mode_select_mid, .mode_select_tri,
    .cpu_freq_select, .current_multiplier_select, .pci_boundary,
    .ctrl0_q(b_ctrl0), .spread_enable(), .video_hub_48(),
    .pci_run(b_pci_run), .cpu_133(), .out_mode(), .outputs_hiz(),
    .outputs_held_low(), .osc_vco_on(), .cpu_cur_mult_6(),
    .transfer_valid(b_valid));
  cssc_smbus_assertions i_chk (.sys_clk, .rst_n, .scl(link.scl),
    .sda(link.sda), .sda_o_dev(link.sda_o_dev),
    .sda_oe_n_dev(link.sda_oe_n_dev), .sda_oe_n_host(link.sda_oe_n_host));
  // Host frames are slow; the ceiling leaves margin over the full run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // Drivers
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d);
    @(posedge sys_clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Straps are captured on the first strobe low after reset
  task automatic do_reset(input logic m, input logic ts, input logic f);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    strap_valid_n <= 1'b1;
    mode_select_mid <= m;
    mode_select_tri <= ts;
    cpu_freq_select <= f;
    current_multiplier_select <= f;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    strap_valid_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic pulse();
    repeat (6) @(posedge sys_clk);
    pci_boundary <= 1'b1;
    @(posedge sys_clk);
    pci_boundary <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  // Released line reads high through the wired pull-up
  task automatic bb(input logic s, input logic c);
    @(posedge sys_clk);
    bad.sda_oe_n_host <= s;
    bad.scl_oe_n_host <= c;
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic bbit(input logic v, output logic s);
    bb(v, 1'b0);
    bb(v, 1'b1);
    s = bad.sda;
    bb(v, 1'b0);
  endtask
  task automatic bframe(input logic [39:0] fr, input int n,
                        input logic [4:0] exp);
    logic s;
    bb(1'b1, 1'b1);
    bb(1'b0, 1'b1);
    bb(1'b0, 1'b0);
    for (int k = 0; k < n; k++) begin
      for (int i = 39 - 8 * k; i > 31 - 8 * k; i--) bbit(fr[i], s);
      bbit(1'b1, s);
      `CHK("ack", exp[4 - k], !s)
    end
    bb(1'b0, 1'b0);
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_straps();
    logic m, f;
    for (int i = 0; i < 6; i++) begin
      m = (i >= 4);
      f = i[0];
      do_reset(m, i[1], f);
      `CHK("mode", m ? (f ? 4'h4 : 4'h8) : (i[1] ? 4'h1 : 4'h2), out_mode)
      `CHK("hiz", m && !f, outputs_hiz)
      `CHK("mult", f, cpu_cur_mult_6)
      if (!m) begin
        `CHK("ctrl0", 8'h19 | {5'h0, i[1], f, 1'b0}, ctrl0_q)
        `CHK("cpu133", f, cpu_133)
      end
    end
    do_reset(1'b0, 1'b1, 1'b1);
    `CHK("pwrup", 4'h3, {spread_enable, video_hub_48, pci_run, osc_vco_on})
    strap_valid_n <= 1'b1;
    mode_select_tri <= 1'b0;
    cpu_freq_select <= 1'b0;
    repeat (2) @(posedge sys_clk);
    strap_valid_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    `CHK("strap_hold", 8'h1F, ctrl0_q)
  endtask
  task automatic t_host();
    av(1'b0, 4'hC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    av(1'b0, cssc_pkg::REG_DATA0, 32'h0);
    `CHK("data_rst", 32'h19, rd)
    for (int c = 0; c < 2; c++) begin
      av(1'b1, cssc_pkg::REG_CTRL, c ? 32'd33 : 32'd0);
      av(1'b0, cssc_pkg::REG_STATUS, 32'h0);
      `CHK("refuse", 1'b0, rd[0])
    end
    av(1'b1, cssc_pkg::REG_DATA0, 32'hFF);
    av(1'b1, cssc_pkg::REG_CTRL, 32'h1);
    av(1'b0, cssc_pkg::REG_STATUS, 32'h0);
    `CHK("busy", 1'b1, rd[0])
    while (rd[0] === 1'b1) av(1'b0, cssc_pkg::REG_STATUS, 32'h0);
    `CHK("nack", 1'b0, rd[1])
    `CHK("ctrl0_w", 8'hBF, ctrl0_q)
    `CHK("valid", 1'b1, transfer_valid)
    `CHK("spread_vch", 2'h3, {spread_enable, video_hub_48})
  endtask
  task automatic t_pins();
    pci_stop_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    `CHK("pci_wait", 1'b1, pci_run)
    pulse();
    `CHK("pci_stop", 1'b0, pci_run)
    pci_stop_n <= 1'b1;
    pulse();
    `CHK("pci_go", 1'b1, pci_run)
    power_down_n <= 1'b0;
    pulse();
    `CHK("pd", 2'h2, {outputs_held_low, osc_vco_on})
    power_down_n <= 1'b1;
    pulse();
    `CHK("pd_off", 2'h1, {outputs_held_low, osc_vco_on})
  endtask
  task automatic t_bad();
    logic [7:0] adr [3] = '{8'hD3, 8'hD0, 8'h52};
    for (int k = 0; k < 3; k++)
      bframe({adr[k], 32'h0}, 1, 5'h00);
    bframe(40'hD2_00_00_00_00, 3, 5'h18);
    bframe(40'hD2_00_21_00_00, 3, 5'h18);
    `CHK("b_invalid", 1'b0, b_valid)
    bframe(40'hD2_00_02_00_FF, 5, 5'h1F);
    `CHK("b_valid", 1'b1, b_valid)
    `CHK("b_ctrl0", 8'h17, b_ctrl0)
    `CHK("b_pci_hold", 1'b1, b_pci_run)
    pulse();
    `CHK("b_pci_off", 1'b0, b_pci_run)
    bframe(40'hD2_00_01_F7_AA, 5, 5'h1E);
    `CHK("b_ctrl0_ro", 8'hB7, b_ctrl0)
  endtask
  // Main sequence
  initial begin
    bad.scl_o_host = 1'b0;
    bad.sda_o_host = 1'b0;
    bad.scl_oe_n_host = 1'b1;
    bad.sda_oe_n_host = 1'b1;
    t_straps();
    t_host();
    t_pins();
    t_bad();
    final_report();
  end
endmodule

// file: bench/cssc_smbus_assertions.sv
// Serial link assertions between host end and device end
`timescale 1ns/1ns
module cssc_smbus_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_o_dev,
  input wire logic sda_oe_n_dev,
  input wire logic sda_oe_n_host
);
  // ==========================================================
  // Frame tracker
  logic       scl_d, sda_d, in_frame;
  logic [3:0] bitcnt;
  logic [5:0] bytecnt;
  logic [7:0] shift, cnt;
  wire        rise = scl && !scl_d;
  wire        ack_slot = rise && bitcnt == 4'h8;
  // Line history, kept through reset so edges stay meaningful
  always_ff @(posedge sys_clk) begin
    scl_d <= scl;
    sda_d <= sda;
  end
  // Bit and byte position; a start restarts, a stop ends the frame
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      in_frame <= 1'b0;
      bitcnt <= 4'h0;
      bytecnt <= 6'h00;
      shift <= 8'h00;
      cnt <= 8'h00;
    end else if (scl && scl_d && sda_d && !sda) begin
      in_frame <= 1'b1;
      bitcnt <= 4'h0;
      bytecnt <= 6'h00;
    end else if (scl && scl_d && !sda_d && sda) begin
      in_frame <= 1'b0;
    end else if (ack_slot) begin
      bitcnt <= 4'h0;
      bytecnt <= bytecnt + 6'h01;
      if (bytecnt == 6'h02)
        cnt <= shift;
    end else if (rise) begin
      bitcnt <= bitcnt + 4'h1;
      shift <= {shift[6:0], sda};
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_addr_ack: assert property (
    ack_slot && bytecnt == 6'h00 |-> sda == (shift != 8'hD2))
    else $error("address byte answered wrongly");
  a_cmd_zero: assert property (
    ack_slot && bytecnt == 6'h01 |-> shift == 8'h00)
    else $error("command code not zero");
  a_count_ack: assert property (
    ack_slot && bytecnt == 6'h02 |-> sda == (shift == 8'h00 || shift > 8'h20))
    else $error("count byte answered wrongly");
  a_data_ack: assert property (
    ack_slot && bytecnt > 6'h02 |-> sda == ({2'h0, bytecnt} - 8'h03 >= cnt))
    else $error("data byte answered wrongly");
  a_ack_held: assert property (
    ack_slot && !sda |-> !sda_oe_n_dev ##1 (!sda_oe_n_dev) [*8])
    else $error("acknowledge not held while clock high");
  a_host_releases: assert property (
    ack_slot |-> sda_oe_n_host)
    else $error("host drives data in acknowledge slot");
  a_dev_idle_quiet: assert property (
    !in_frame |-> sda_oe_n_dev)
    else $error("device drives data outside a frame");
  a_dev_stable: assert property (
    scl && scl_d |-> $stable(sda_oe_n_dev))
    else $error("device changes data while clock high");
  a_dev_open_drain: assert property (
    !sda_oe_n_dev |-> !sda_o_dev)
    else $error("device drives data high");
endmodule

// file: rtl/cssc_device.sv
// Clock device end: serial slave, control byte 0 and output gating
// ==========================================================
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
module cssc_device (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  cssc_smbus_if.dev       bus,
  input  wire logic       power_down_n,
  input  wire logic       pci_stop_n,
  input  wire logic       strap_valid_n,
  input  wire logic       mode_select_mid,
  input  wire logic       mode_select_tri,
  input  wire logic       cpu_freq_select,
  input  wire logic       current_multiplier_select,
  input  wire logic       pci_boundary,
  output logic [7:0]      ctrl0_q,
  output logic            spread_enable,
  output logic            video_hub_48,
  output logic            pci_run,
  output logic            cpu_133,
  output logic [3:0]      out_mode,
  output logic            outputs_hiz,
  output logic            outputs_held_low,
  output logic            osc_vco_on,
  output logic            cpu_cur_mult_6,
  output logic            transfer_valid
);
  // ==========================================================
  // Pin synchronisers: three stages, accept when 2nd and 3rd agree
  logic [2:0] scl_sync_reg, sda_sync_reg, pd_sync_reg, stop_sync_reg;
  logic       scl_reg, sda_reg, scl_d_reg, sda_d_reg;
  logic       pd_n_reg, stop_n_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_sync_reg  <= 3'h7;
      sda_sync_reg  <= 3'h7;
      pd_sync_reg   <= 3'h7;
      stop_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg  <= {scl_sync_reg[1:0], bus.scl};
      sda_sync_reg  <= {sda_sync_reg[1:0], bus.sda};
      pd_sync_reg   <= {pd_sync_reg[1:0], power_down_n};
      stop_sync_reg <= {stop_sync_reg[1:0], pci_stop_n};
    end
  end
  // Filtered levels update only on agreement of stages two and three
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_reg    <= 1'b1;
      sda_reg    <= 1'b1;
      pd_n_reg   <= 1'b1;
      stop_n_reg <= 1'b1;
      scl_d_reg  <= 1'b1;
      sda_d_reg  <= 1'b1;
    end else begin
      if (scl_sync_reg[1] == scl_sync_reg[2]) scl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2]) sda_reg <= sda_sync_reg[2];
      if (pd_sync_reg[1] == pd_sync_reg[2]) pd_n_reg <= pd_sync_reg[2];
      if (stop_sync_reg[1] == stop_sync_reg[2])
        stop_n_reg <= stop_sync_reg[2];
      scl_d_reg <= scl_reg;
      sda_d_reg <= sda_reg;
    end
  end
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise   = scl_reg & ~scl_d_reg;
  assign scl_fall   = ~scl_reg & scl_d_reg;
  assign start_cond = scl_reg & scl_d_reg & sda_d_reg & ~sda_reg;
  assign stop_cond  = scl_reg & scl_d_reg & ~sda_d_reg & sda_reg;

  // ==========================================================
  // Serial slave state machine
  typedef enum logic [5:0] {
    CSSC_ST_IDLE = 6'h01,
    CSSC_ST_ADDR = 6'h02,
    CSSC_ST_CMD  = 6'h04,
    CSSC_ST_CNT  = 6'h08,
    CSSC_ST_DATA = 6'h10,
    CSSC_ST_IGN  = 6'h20
  } cssc_dev_st_e;
  cssc_dev_st_e st_reg;
  logic [2:0]   bit_cnt_reg;
  logic [7:0]   shift_reg;
  logic [5:0]   remain_reg;
  logic [5:0]   byte_idx_reg;
  logic         ack_phase_reg;
  logic         ack_drive_reg;
  logic         byte_done;
  logic [7:0]   byte_in;
  assign byte_in   = {shift_reg[6:0], sda_reg};
  assign byte_done = scl_rise & ~ack_phase_reg & (bit_cnt_reg == 3'h7);

  // Bit counter and shift register, MSB first
  always_ff @(posedge sys_clk) begin
    if (!rst_n || start_cond) begin
      bit_cnt_reg   <= 3'h0;
      ack_phase_reg <= 1'b0;
      shift_reg     <= 8'h00;
    end else if (scl_rise && !ack_phase_reg) begin
      shift_reg   <= byte_in;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) ack_phase_reg <= 1'b1;
    end else if (scl_rise && ack_phase_reg) begin
      ack_phase_reg <= 1'b0; // Acknowledge clock is not a data bit
    end
  end

  // Byte-level sequencing of the block write
  localparam logic [6:0] SLAVE_ADDR_W = cssc_pkg::SLAVE_ADDR;
  logic ack_this;
  always_comb begin
    ack_this = 1'b0;
    unique case (st_reg)
      CSSC_ST_ADDR: ack_this = (byte_in == {SLAVE_ADDR_W, 1'b0});
      CSSC_ST_CMD:  ack_this = 1'b1;
      CSSC_ST_CNT:  ack_this = (byte_in != 8'h00) &&
                               (byte_in <= 8'h20);
      CSSC_ST_DATA: ack_this = (remain_reg != 6'h00);
      CSSC_ST_IDLE, CSSC_ST_IGN: ack_this = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || stop_cond) begin
      st_reg         <= CSSC_ST_IDLE;
      remain_reg     <= 6'h00;
      byte_idx_reg   <= 6'h00;
      if (!rst_n) transfer_valid <= 1'b0; // Stands past the stop
    end else if (start_cond) begin
      st_reg         <= CSSC_ST_ADDR;
      byte_idx_reg   <= 6'h00;
      transfer_valid <= 1'b0;
    end else begin
      if (byte_done) begin
        unique case (st_reg)
          CSSC_ST_ADDR: st_reg <= ack_this ? CSSC_ST_CMD : CSSC_ST_IGN;
          CSSC_ST_CMD:  st_reg <= CSSC_ST_CNT;
          CSSC_ST_CNT: begin
            st_reg     <= ack_this ? CSSC_ST_DATA : CSSC_ST_IGN;
            remain_reg <= byte_in[5:0];
            if (byte_in == 8'h20) remain_reg <= 6'h20;
          end
          CSSC_ST_DATA: begin
            if (ack_this) begin
              remain_reg   <= remain_reg - 6'h01;
              byte_idx_reg <= byte_idx_reg + 6'h01;
            end else begin
              st_reg <= CSSC_ST_IGN;
            end
          end
          CSSC_ST_IDLE, CSSC_ST_IGN: st_reg <= st_reg;
        endcase
      end
      // Count acknowledge sampled by host on SCL high
      if (scl_rise && ack_drive_reg && st_reg == CSSC_ST_DATA &&
          byte_idx_reg == 6'h00)
        transfer_valid <= 1'b1;
    end
  end

  // ACK driving: pull SDA low from SCL fall after bit 8 to next fall
  logic ack_pend_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || start_cond || stop_cond) begin
      ack_pend_reg     <= 1'b0;
      ack_drive_reg    <= 1'b0;
      bus.sda_o_dev    <= 1'b0;
      bus.sda_oe_n_dev <= 1'b1;
    end else begin
      if (byte_done) ack_pend_reg <= ack_this;
      if (scl_fall && ack_pend_reg) begin
        ack_pend_reg     <= 1'b0;
        ack_drive_reg    <= 1'b1;
        bus.sda_oe_n_dev <= 1'b0;
      end else if (scl_fall && ack_drive_reg) begin
        ack_drive_reg    <= 1'b0;
        bus.sda_oe_n_dev <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Control byte 0: only writable bits stored, strap bits from the captured straps, others fixed
  logic spread_reg, vch_reg, pci_run_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      spread_reg  <= cssc_pkg::CTRL0_RESET[cssc_pkg::BIT_SPREAD];
      vch_reg     <= cssc_pkg::CTRL0_RESET[cssc_pkg::BIT_VCH_SEL];
      pci_run_reg <= cssc_pkg::CTRL0_RESET[cssc_pkg::BIT_PCI_RUN];
    end else if (byte_done && st_reg == CSSC_ST_DATA && ack_this &&
                 byte_idx_reg == 6'h00) begin
      spread_reg  <= byte_in[cssc_pkg::BIT_SPREAD];
      vch_reg     <= byte_in[cssc_pkg::BIT_VCH_SEL];
      pci_run_reg <= byte_in[cssc_pkg::BIT_PCI_RUN];
    end
  end

  // Strap capture once while the strobe is low, then locked
  logic straps_taken_reg, mode_strap_reg, freq_strap_reg, mid_reg, mult_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      straps_taken_reg <= 1'b0;
      mode_strap_reg   <= 1'b0;
      freq_strap_reg   <= 1'b0;
      mid_reg          <= 1'b0;
      mult_reg         <= 1'b0;
    end else if (!strap_valid_n && !straps_taken_reg) begin
      straps_taken_reg <= 1'b1;
      mode_strap_reg   <= mode_select_tri;
      freq_strap_reg   <= cpu_freq_select;
      mid_reg          <= mode_select_mid;
      mult_reg         <= current_multiplier_select;
    end
  end

  // Read-back image and decoded output control, all registered
  cssc_pkg::cssc_mode_e mode_next;
  always_comb begin
    if (mid_reg)
      mode_next = freq_strap_reg ? cssc_pkg::CSSC_MODE_TEST
                                 : cssc_pkg::CSSC_MODE_HIZ;
    else
      mode_next = mode_strap_reg ? cssc_pkg::CSSC_MODE_BUFFERED
                                 : cssc_pkg::CSSC_MODE_INTERNAL;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl0_q          <= cssc_pkg::CTRL0_RESET;
      spread_enable    <= 1'b0;
      video_hub_48     <= 1'b0;
      pci_run          <= 1'b1;
      cpu_133          <= 1'b0;
      out_mode         <= cssc_pkg::CSSC_MODE_INTERNAL;
      outputs_hiz      <= 1'b0;
      outputs_held_low <= 1'b0;
      osc_vco_on       <= 1'b1;
      cpu_cur_mult_6   <= 1'b0;
    end else begin
      ctrl0_q <= {spread_reg, 1'b0, vch_reg, 1'b1, pci_run_reg,
                  mode_strap_reg, freq_strap_reg, 1'b1};
      spread_enable    <= spread_reg & pd_n_reg;
      video_hub_48     <= vch_reg;
      cpu_133          <= freq_strap_reg;
      out_mode         <= mode_next;
      outputs_hiz      <= (mode_next == cssc_pkg::CSSC_MODE_HIZ);
      outputs_held_low <= ~pd_n_reg;
      osc_vco_on       <= pd_n_reg;
      cpu_cur_mult_6   <= mult_reg;
      // PCI gate moves only at an output clock boundary
      if (pci_boundary)
        pci_run <= pci_run_reg & pd_n_reg & stop_n_reg;
    end
  end
endmodule

// file: rtl/cssc_host.sv
// Host end: Avalon-MM controlled block-write master on the serial link
`timescale 1ns/1ns
module cssc_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  cssc_smbus_if.host       bus,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  // ==========================================================
  // Registers: count (1..32) and one data byte fixed for all data
  logic [5:0] count_reg;
  logic [7:0] data_reg;
  logic       go_reg, busy_reg, nack_reg;
  logic [1:0] phase_reg;
  // Bus slave: one wait cycle then answer
  logic acc_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      acc_reg         <= (avs_read | avs_write) & ~acc_reg;
      avs_waitrequest <= ~((avs_read | avs_write) & ~acc_reg);
      unique case (avs_address)
        cssc_pkg::REG_CTRL:   avs_readdata <= {26'h0, count_reg};
        cssc_pkg::REG_STATUS: avs_readdata <= {30'h0, nack_reg, busy_reg};
        cssc_pkg::REG_DATA0:  avs_readdata <= {24'h0, data_reg};
        default:              avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
  // Software writes: count launches a frame, data sets the byte value
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_reg <= 6'h01;
      data_reg  <= cssc_pkg::CTRL0_RESET;
      go_reg    <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (avs_write && acc_reg && !busy_reg) begin
        if (avs_address == cssc_pkg::REG_CTRL &&
            avs_writedata[5:0] != 6'h00 && avs_writedata[5:0] <= 6'h20) begin
          count_reg <= avs_writedata[5:0];
          go_reg    <= 1'b1;
        end
        if (avs_address == cssc_pkg::REG_DATA0)
          data_reg <= avs_writedata[7:0];
      end
    end
  end
  // ==========================================================
  // Serial engine: quarter-period enable and byte sequence
  logic [8:0] div_reg;
  logic       tick;
  assign tick = (div_reg == 9'(cssc_pkg::SCL_QUARTER_CYC - 1));
  always_ff @(posedge sys_clk) begin
    if (!rst_n || tick) div_reg <= 9'h000;
    else                div_reg <= div_reg + 9'h001;
  end
  typedef enum logic [4:0] {
    CSSC_H_IDLE  = 5'h01,
    CSSC_H_START = 5'h02,
    CSSC_H_BITS  = 5'h04,
    CSSC_H_STOP  = 5'h08,
    CSSC_H_DONE  = 5'h10
  } cssc_host_st_e;
  cssc_host_st_e hst_reg;
  logic [5:0] byte_no_reg;
  logic [3:0] bit_no_reg;
  logic [7:0] tx_byte;
  // Frame order: address+W, command 00h, count, data bytes
  always_comb begin
    if (byte_no_reg == 6'h00)      tx_byte = {cssc_pkg::SLAVE_ADDR, 1'b0};
    else if (byte_no_reg == 6'h01) tx_byte = cssc_pkg::CMD_CODE;
    else if (byte_no_reg == 6'h02) tx_byte = {2'h0, count_reg};
    else                           tx_byte = data_reg;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hst_reg           <= CSSC_H_IDLE;
      busy_reg          <= 1'b0;
      nack_reg          <= 1'b0;
      phase_reg         <= 2'h0;
      byte_no_reg       <= 6'h00;
      bit_no_reg        <= 4'h0;
      bus.scl_o_host    <= 1'b0;
      bus.scl_oe_n_host <= 1'b1;
      bus.sda_o_host    <= 1'b0;
      bus.sda_oe_n_host <= 1'b1;
    end else if (go_reg) begin
      hst_reg  <= CSSC_H_START;
      busy_reg <= 1'b1;
      nack_reg <= 1'b0;
      byte_no_reg <= 6'h00;
      phase_reg <= 2'h0;
    end else if (tick) begin
      phase_reg <= phase_reg + 2'h1;
      unique case (hst_reg)
        CSSC_H_IDLE: phase_reg <= 2'h0;
        CSSC_H_START: begin
          if (phase_reg == 2'h1) bus.sda_oe_n_host <= 1'b0;
          if (phase_reg == 2'h3) begin
            bus.scl_oe_n_host <= 1'b0;
            hst_reg    <= CSSC_H_BITS;
            bit_no_reg <= 4'h0;
          end
        end
        CSSC_H_BITS: begin
          if (phase_reg == 2'h0)  // Data changes mid SCL low
            bus.sda_oe_n_host <= (bit_no_reg == 4'h8) ? 1'b1
                                 : tx_byte[3'(7 - bit_no_reg)];
          if (phase_reg == 2'h1) bus.scl_oe_n_host <= 1'b1;
          if (phase_reg == 2'h2 && bit_no_reg == 4'h8 && bus.sda)
            nack_reg <= 1'b1;
          if (phase_reg == 2'h3) begin
            bus.scl_oe_n_host <= 1'b0;
            bit_no_reg <= bit_no_reg + 4'h1;
            if (bit_no_reg == 4'h8) begin
              bit_no_reg  <= 4'h0;
              byte_no_reg <= byte_no_reg + 6'h01;
              if (nack_reg || byte_no_reg == 6'(count_reg + 6'h02))
                hst_reg <= CSSC_H_STOP;
            end
          end
        end
        CSSC_H_STOP: begin
          if (phase_reg == 2'h0) bus.sda_oe_n_host <= 1'b0;
          if (phase_reg == 2'h1) bus.scl_oe_n_host <= 1'b1;
          if (phase_reg == 2'h3) begin
            bus.sda_oe_n_host <= 1'b1;
            hst_reg <= CSSC_H_DONE;
          end
        end
        CSSC_H_DONE: begin
          busy_reg <= 1'b0;
          hst_reg  <= CSSC_H_IDLE;
        end
      endcase
    end
  end
endmodule

// file: rtl/cssc_pkg.sv
// Shared constants and types for the clock synthesizer control link
package cssc_pkg;
  // ==========================================================
  // Serial framing
  localparam logic [6:0] SLAVE_ADDR     = 7'h69;
  localparam logic [7:0] CMD_CODE       = 8'h00;
  localparam int         COUNT_MIN      = 1;
  localparam int         COUNT_MAX      = 32;
  // ==========================================================
  // Control byte 0 layout and power-up values
  localparam int         BIT_SPREAD     = 7;
  localparam int         BIT_RSV6       = 6;
  localparam int         BIT_VCH_SEL    = 5;
  localparam int         BIT_RSV4       = 4;
  localparam int         BIT_PCI_RUN    = 3;
  localparam int         BIT_MODE_STRAP = 2;
  localparam int         BIT_FREQ_STRAP = 1;
  localparam int         BIT_RSV0       = 0;
  localparam logic [7:0] CTRL0_RESET    = 8'h19;
  localparam logic [7:0] CTRL0_WMASK    = 8'hA8;
  // ==========================================================
  // Host timing: serial clock quarter period in system cycles
  localparam int         SCL_QUARTER_NS = 2500;
  localparam int         CLK_PERIOD_NS  = 8;
  localparam int         SCL_QUARTER_CYC = SCL_QUARTER_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Avalon register map of the host controller
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h4;
  localparam logic [3:0] REG_DATA0      = 4'h8;
  // Output modes decoded from the straps
  typedef enum logic [3:0] {
    CSSC_MODE_BUFFERED = 4'h1,
    CSSC_MODE_INTERNAL = 4'h2,
    CSSC_MODE_TEST     = 4'h4,
    CSSC_MODE_HIZ      = 4'h8
  } cssc_mode_e;
endpackage

// file: rtl/cssc_smbus_if.sv
// Two-wire serial link joining the host controller and the clock device
`timescale 1ns/1ns
interface cssc_smbus_if;
  logic scl_o_host;
  logic scl_oe_n_host;
  logic sda_o_host;
  logic sda_oe_n_host;
  logic sda_o_dev;
  logic sda_oe_n_dev;
  logic scl;
  logic sda;
  // Open-drain wired AND: pulled high unless a party drives low
  assign scl = scl_oe_n_host ? 1'b1 : scl_o_host;
  assign sda = (sda_oe_n_host ? 1'b1 : sda_o_host) &
               (sda_oe_n_dev ? 1'b1 : sda_o_dev);
  modport host (
    output scl_o_host,
    output scl_oe_n_host,
    output sda_o_host,
    output sda_oe_n_host,
    input  scl,
    input  sda
  );
  modport dev (
    output sda_o_dev,
    output sda_oe_n_dev,
    input  scl,
    input  sda
  );
endinterface
